/* core/pinmux_consts.svh */
// Register offsets, field positions, reset values and timing figures.
`ifndef PINMUX_CONSTS_SVH
`define PINMUX_CONSTS_SVH

// ==========================================================================
// Register offsets
`define RA_CTRL      8'h85
`define RA_DIR       8'h86
`define RA_POL       8'h87
`define RA_FN_A      8'h8c
`define RA_FN_B      8'h8d
`define RA_FN_C      8'h8e
`define RA_FN_D      8'h8f

// ==========================================================================
// Field positions
`define DBT_LSB      6
`define DBT_W        2

// ==========================================================================
// Reset values
`define RST_DIR      13'h0ffc
`define RST_POL      13'h0ffc
`define RST_FN_A     16'h0013
`define RST_FN_B     16'h0000
`define RST_FN_C     16'h0000
`define RST_FN_D     4'h3
`define RST_DBT      2'h0

// ==========================================================================
// Timing
`define CLK_PERIOD_NS 10
`define DB_T0_NS     64000
`define DB_T1_NS     500000
`define DB_T2_NS     1000000
`define DB_T3_NS     4000000
`define DB_CNT_W     19

`endif

/* core/pinmux_pkg.sv */
// Types shared by the pin configuration and multiplexing logic.
`include "pinmux_consts.svh"

package pinmux_pkg;

   // =======================================================================
   // Internal signals that an output pin can carry
   typedef enum logic [4:0] {
      src_gpio, src_power_on_request, src_p_clk, src_vrtc, src_clk32k,
      src_mem_reset_n, src_reset_n, src_do_conf, src_por_n,
      src_vcc_fault_n, src_batt_fault_n, src_microphone_detect,
      src_mic_short, src_ada, src_adc_lrclk, src_codec_opclk,
      src_converter5_undervoltage_flag, src_converter5_clock_out,
      src_flash_out, src_adc_bclk, src_isink_c, src_isink_d,
      src_isink_e, src_line_gt_batt, src_charge_ind, src_line_sw,
      src_rtc, src_adc_lrclkb
   } out_src_e;

   localparam int SRC_N = int'(src_adc_lrclkb) + 1;

   // =======================================================================
   // Internal requests that an input pin can raise
   typedef enum logic [4:0] {
      fn_gpio, fn_power_on_request, fn_ldo_enable, fn_power_off_request,
      fn_flash, fn_wakeup, fn_clk32k_in, fn_low_power1, fn_low_power2,
      fn_low_power3, fn_chip_reset, fn_manual_reset, fn_mask,
      fn_hib_edge, fn_hib_level, fn_adc_lrclk, fn_adc_bclk, fn_heartbeat
   } in_func_e;

   localparam int FN_N = int'(fn_heartbeat) + 1;

   typedef logic [SRC_N-1:0] src_vec_t;
   typedef logic [FN_N-1:0]  req_vec_t;

   typedef struct packed {
      logic [12:0] o;
      logic [12:0] oe_n;
   } pin_pads_s;

   typedef struct packed {
      logic [12:0]      dir;
      logic [12:0]      pol;
      logic [12:0][3:0] fn;
      logic [1:0]       dbt;
      logic [15:0]      rdata;
      logic             rvalid;
      pin_pads_s        pads;
      logic [12:0]      act_prev;
      logic [12:0]      pin_event;
      req_vec_t         req;
      logic             hib_edge;
   } mux_state_s;

   typedef struct packed {
      logic [`DB_CNT_W-1:0] cnt;
      logic                 stable;
   } db_state_s;

endpackage

/* core/pin_debounce.sv */
// Input debouncer: a level is taken once it has stood for the limit.
`timescale 1ns/10ps
`include "pinmux_consts.svh"

module pin_debounce (
   input  wire logic                 ref_clk, // System clock.
   input  wire logic                 rstn,    // Asynchronous reset.
   input  wire logic                 raw,     // Pin level.
   input  wire logic [`DB_CNT_W-1:0] limit,   // Cycles to stand.
   output logic                      stable   // Debounced level.
);
   import pinmux_pkg::*;

   db_state_s st_ff;
   db_state_s nxt_st;

   always_comb begin
      nxt_st = st_ff;
      if (raw == st_ff.stable) begin
         nxt_st.cnt = '0;
      end else if (st_ff.cnt >= limit - `DB_CNT_W'(1)) begin
         nxt_st.stable = raw;
         nxt_st.cnt    = '0;
      end else begin
         nxt_st.cnt = st_ff.cnt + `DB_CNT_W'(1);
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign stable = st_ff.stable;

endmodule

/* core/gpio_pin_config_mux.sv */
// Configuration registers and function multiplexing for pins 0 to 12.
// Notes on behaviour
// [RL1] Direction bit per pin: 0 is output, 1 is input.
// [RL2] Polarity/type bit: input 0 low, 1 high; output 0 CMOS, 1 drain.
// [RL3] All fields take fixed factory defaults on state machine reset.
// [RL4] Select A holds pin 0..3 codes at 3:0..15:12; 0000 is plain.
// [RL5] Select B holds pin 4..7 codes in four nibbles.
// [RL6] Select C holds pin 8..11 codes in four nibbles.
// [RL7] Select D holds only pin 12 code in bits 3:0.
// [RL8] Pin 5 output codes 1000, 1001, 1010 give converter flag, clock, mic.
// [RL9] Pin 5 input 0011 edge hibernate, 0101 level hibernate.
// [RL10] Pin 6 input 0011 edge hibernate, 0100 level hibernate.
// [RL11] Pin 4 input 0011 level hibernate, 0100 converter mask input.
// [RL12] Pin 9 input 0100 is level hibernate.
// [RL13] Pin 8 input 0100 is edge hibernate.
// [RL14] Rising-edge events look at the level after polarity is applied.
// [RL15] Shared debounce field: 64us, 0.5ms, 1ms or 4ms.
// [RL16] Direction chooses input or output meaning of the code.
// [RL17] Unlisted codes leave the pin in plain general-purpose operation.
`timescale 1ns/10ps
`include "pinmux_consts.svh"

module gpio_pin_config_mux #(
   parameter int NPINS   = 13,
   parameter int DB_CYC0 = (`DB_T0_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter int DB_CYC1 = (`DB_T1_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter int DB_CYC2 = (`DB_T2_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter int DB_CYC3 = (`DB_T3_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
   input  wire logic              ref_clk,         // System clock.
   input  wire logic              rstn,            // State machine reset.
   input  wire logic [7:0]        reg_addr,        // Register offset.
   input  wire logic [15:0]       reg_wdata,       // Write data.
   input  wire logic              reg_wr,          // Write strobe.
   input  wire logic              reg_rd,          // Read strobe.
   output logic [15:0]            reg_rdata,       // Read data.
   output logic                   reg_rvalid,      // Read data valid.
   input  wire logic [12:0]       pin_i,           // Pin levels.
   output pinmux_pkg::pin_pads_s  pin_pads,        // Pin drive and enable.
   input  wire logic [12:0]       pin_out_level,   // Plain output levels.
   input  wire logic [12:0]       pin_edge_select, // 1 gives both edges.
   input  wire pinmux_pkg::src_vec_t int_src,      // Internal signals.
   output logic [12:0]            pin_in_level,    // Active input levels.
   output logic [12:0]            pin_event,       // Edge events.
   output pinmux_pkg::req_vec_t   func_req,        // Input function levels.
   output logic                   hib_edge_pulse   // Edge hibernate request.
);
   import pinmux_pkg::*;

   // =======================================================================
   // Parameter checks
   if (NPINS != 13) begin : g_bad_pins
      $error("Pin count must be 13.");
   end
   if (DB_CYC0 < 1 || DB_CYC1 < 1 || DB_CYC2 < 1 || DB_CYC3 < 1 ||
       DB_CYC0 >= (1 << `DB_CNT_W) || DB_CYC1 >= (1 << `DB_CNT_W) ||
       DB_CYC2 >= (1 << `DB_CNT_W) ||
       DB_CYC3 >= (1 << `DB_CNT_W)) begin : g_bad_db
      $error("Debounce counts do not fit the counter.");
   end

   // =======================================================================
   // Function decoding
   function automatic out_src_e out_sel(input logic [3:0] pin,
                                        input logic [3:0] code);
      out_src_e s;
      s = src_gpio;
      case ({pin, code}) // RL16
         8'h01: s = src_power_on_request;
         8'h02: s = src_vrtc;
         8'h03: s = src_por_n;
         8'h04: s = src_reset_n;
         8'h11: s = src_do_conf;
         8'h12: s = src_reset_n;
         8'h13: s = src_mem_reset_n;
         8'h14: s = src_clk32k;
         8'h21: s = src_power_on_request;
         8'h22: s = src_vrtc;
         8'h23: s = src_clk32k;
         8'h24: s = src_reset_n;
         8'h31: s = src_p_clk;
         8'h32: s = src_vrtc;
         8'h33: s = src_clk32k;
         8'h34: s = src_mem_reset_n;
         8'h41: s = src_mem_reset_n;
         8'h42: s = src_ada;
         8'h43: s = src_flash_out;
         8'h44: s = src_vcc_fault_n;
         8'h45: s = src_mic_short;
         8'h4a: s = src_microphone_detect;
         8'h51: s = src_p_clk;
         8'h52: s = src_adc_lrclk;
         8'h53: s = src_clk32k;
         8'h54: s = src_batt_fault_n;
         8'h55: s = src_mic_short;
         8'h56: s = src_ada;
         8'h57: s = src_codec_opclk;
         8'h58: s = src_converter5_undervoltage_flag; // RL8
         8'h59: s = src_converter5_clock_out; // RL8
         8'h5a: s = src_microphone_detect; // RL8
         8'h61: s = src_mem_reset_n;
         8'h62: s = src_ada;
         8'h63: s = src_rtc;
         8'h64: s = src_microphone_detect;
         8'h65: s = src_mic_short;
         8'h66: s = src_adc_lrclkb;
         8'h71: s = src_p_clk;
         8'h72: s = src_vcc_fault_n;
         8'h73: s = src_batt_fault_n;
         8'h74: s = src_microphone_detect;
         8'h75: s = src_mic_short;
         8'h76: s = src_ada;
         8'h81: s = src_vcc_fault_n;
         8'h82: s = src_adc_bclk;
         8'h83: s = src_batt_fault_n;
         8'h84: s = src_reset_n;
         8'h91: s = src_vcc_fault_n;
         8'h92: s = src_line_gt_batt;
         8'h93: s = src_batt_fault_n;
         8'h94: s = src_mem_reset_n;
         8'ha1: s = src_isink_c;
         8'ha2: s = src_line_gt_batt;
         8'ha3: s = src_charge_ind;
         8'hb1: s = src_isink_d;
         8'hb2: s = src_line_gt_batt;
         8'hb3: s = src_charge_ind;
         8'hc1: s = src_isink_e;
         8'hc2: s = src_line_gt_batt;
         8'hc3: s = src_line_sw;
         8'hc4: s = src_clk32k;
         default: s = src_gpio; // RL17
      endcase
      return s;
   endfunction

   function automatic in_func_e in_sel(input logic [3:0] pin,
                                       input logic [3:0] code);
      in_func_e f;
      f = fn_gpio;
      case ({pin, code}) // RL16
         8'h01: f = fn_power_on_request;
         8'h02: f = fn_ldo_enable;
         8'h03: f = fn_low_power1;
         8'h04: f = fn_power_off_request;
         8'h05: f = fn_chip_reset;
         8'h11: f = fn_power_on_request;
         8'h12: f = fn_ldo_enable;
         8'h13: f = fn_low_power2;
         8'h14: f = fn_wakeup;
         8'h21: f = fn_power_on_request;
         8'h22: f = fn_wakeup;
         8'h23: f = fn_clk32k_in;
         8'h24: f = fn_low_power3;
         8'h31: f = fn_power_on_request;
         8'h32: f = fn_ldo_enable;
         8'h33: f = fn_power_off_request;
         8'h34: f = fn_flash;
         8'h41: f = fn_manual_reset;
         8'h42: f = fn_flash;
         8'h43: f = fn_hib_level; // RL11
         8'h44: f = fn_mask; // RL11
         8'h45: f = fn_chip_reset;
         8'h51: f = fn_low_power1;
         8'h52: f = fn_adc_lrclk;
         8'h53: f = fn_hib_edge; // RL9
         8'h54: f = fn_power_off_request;
         8'h55: f = fn_hib_level; // RL9
         8'h61: f = fn_low_power2;
         8'h62: f = fn_flash;
         8'h63: f = fn_hib_edge; // RL10
         8'h64: f = fn_hib_level; // RL10
         8'h71: f = fn_low_power3;
         8'h72: f = fn_mask;
         8'h73: f = fn_hib_level;
         8'h81: f = fn_manual_reset;
         8'h82: f = fn_adc_bclk;
         8'h83: f = fn_power_off_request;
         8'h84: f = fn_hib_edge; // RL13
         8'h91: f = fn_heartbeat;
         8'h92: f = fn_mask;
         8'h93: f = fn_power_off_request;
         8'h94: f = fn_hib_level; // RL12
         8'ha3: f = fn_power_off_request;
         8'hb2: f = fn_wakeup;
         8'hc1: f = fn_chip_reset;
         default: f = fn_gpio; // RL17
      endcase
      return f;
   endfunction

   // =======================================================================
   // State
   localparam mux_state_s RST_STATE = '{
      dir:       `RST_DIR,
      pol:       `RST_POL,
      fn:        {`RST_FN_D, `RST_FN_C, `RST_FN_B, `RST_FN_A},
      dbt:       `RST_DBT,
      pads:      '{o: '0, oe_n: '1},
      default:   '0
   };

   mux_state_s             st_ff;
   mux_state_s             nxt_st;
   logic [`DB_CNT_W-1:0]   db_limit;
   logic [12:0]            db_level;
   logic [12:0]            act_raw;
   logic [12:0]            act_db;
   logic [12:0]            rise;
   logic [12:0]            fall;

   // =======================================================================
   // Debounce
   always_comb begin
      case (st_ff.dbt) // RL15
         2'h0:    db_limit = `DB_CNT_W'(DB_CYC0);
         2'h1:    db_limit = `DB_CNT_W'(DB_CYC1);
         2'h2:    db_limit = `DB_CNT_W'(DB_CYC2);
         default: db_limit = `DB_CNT_W'(DB_CYC3);
      endcase
   end

   for (genvar p = 0; p < 13; p++) begin : g_db
      pin_debounce u_db (
         .ref_clk (ref_clk),
         .rstn    (rstn),
         .raw     (pin_i[p]),
         .limit   (db_limit),
         .stable  (db_level[p])
      );
   end

   // Active-low inputs are inverted on the raw path and after the debouncer.
   assign act_raw = pin_i ~^ st_ff.pol; // RL2
   assign act_db  = db_level ~^ st_ff.pol; // RL2
   assign rise    = act_db & ~st_ff.act_prev; // RL14
   assign fall    = ~act_db & st_ff.act_prev;

   // =======================================================================
   // Next state
   always_comb begin
      in_func_e  f;
      out_src_e  s;
      logic      v;
      f      = fn_gpio;
      s      = src_gpio;
      v      = 1'b0;
      nxt_st = st_ff;
      nxt_st.rvalid   = 1'b0;
      nxt_st.act_prev = act_db;
      nxt_st.req      = '0;
      nxt_st.hib_edge = 1'b0;

      if (reg_wr) begin
         case (reg_addr)
            `RA_CTRL: nxt_st.dbt = reg_wdata[`DBT_LSB +: `DBT_W]; // RL15
            `RA_DIR:  nxt_st.dir = reg_wdata[12:0]; // RL1
            `RA_POL:  nxt_st.pol = reg_wdata[12:0]; // RL2
            `RA_FN_A: nxt_st.fn[3:0] = reg_wdata; // RL4
            `RA_FN_B: nxt_st.fn[7:4] = reg_wdata; // RL5
            `RA_FN_C: nxt_st.fn[11:8] = reg_wdata; // RL6
            `RA_FN_D: nxt_st.fn[12] = reg_wdata[3:0]; // RL7
            default:  nxt_st.dbt = st_ff.dbt;
         endcase
      end

      if (reg_rd) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rdata  = '0;
         case (reg_addr)
            `RA_CTRL: nxt_st.rdata[`DBT_LSB +: `DBT_W] = st_ff.dbt;
            `RA_DIR:  nxt_st.rdata[12:0] = st_ff.dir;
            `RA_POL:  nxt_st.rdata[12:0] = st_ff.pol;
            `RA_FN_A: nxt_st.rdata = st_ff.fn[3:0];
            `RA_FN_B: nxt_st.rdata = st_ff.fn[7:4];
            `RA_FN_C: nxt_st.rdata = st_ff.fn[11:8];
            `RA_FN_D: nxt_st.rdata[3:0] = st_ff.fn[12];
            default:  nxt_st.rdata = '0;
         endcase
      end

      for (int i = 0; i < 13; i++) begin
         nxt_st.pin_event[i] = st_ff.dir[i] &
            (pin_edge_select[i] ? (rise[i] | fall[i]) : rise[i]); // RL14
         if (st_ff.dir[i]) begin // RL1
            f = in_sel(4'(i), st_ff.fn[i]);
            nxt_st.pads.o[i]    = 1'b0;
            nxt_st.pads.oe_n[i] = 1'b1;
            // Clock inputs bypass the debouncer, which would swallow them.
            if (f == fn_clk32k_in || f == fn_adc_lrclk || f == fn_adc_bclk)
            begin
               nxt_st.req[f] = nxt_st.req[f] | act_raw[i];
            end else if (f == fn_hib_edge) begin
               nxt_st.hib_edge = nxt_st.hib_edge | rise[i]; // RL9
            end else if (f != fn_gpio) begin
               nxt_st.req[f] = nxt_st.req[f] | act_db[i];
            end
         end else begin
            s = out_sel(4'(i), st_ff.fn[i]);
            v = (s == src_gpio) ? pin_out_level[i] : int_src[s];
            if (st_ff.pol[i]) begin // RL2
               nxt_st.pads.o[i]    = 1'b0;
               nxt_st.pads.oe_n[i] = v;
            end else begin
               nxt_st.pads.o[i]    = v;
               nxt_st.pads.oe_n[i] = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_ff <= RST_STATE; // RL3
      end else begin
         st_ff <= nxt_st;
      end
   end

   // =======================================================================
   // Outputs
   assign reg_rdata      = st_ff.rdata;
   assign reg_rvalid     = st_ff.rvalid;
   assign pin_pads       = st_ff.pads;
   assign pin_in_level   = st_ff.act_prev;
   assign pin_event      = st_ff.pin_event;
   assign func_req       = st_ff.req;
   assign hib_edge_pulse = st_ff.hib_edge;

endmodule

/* bench/board_pins.sv */
// Board side of the thirteen pins: board drivers and resulting pin levels.
`timescale 1ns/10ps

module board_pins (
   input  wire pinmux_pkg::pin_pads_s pads,  // Device pad drive.
   input  wire logic [12:0]           ext,   // Board driver levels.
   output logic [12:0]                level  // Levels seen at the pins.
);
   import pinmux_pkg::*;

   // An enabled pad wins the wire; a released pin shows the board level.
   assign level = (pads.oe_n & ext) | (~pads.oe_n & pads.o);
endmodule

/* bench/gpio_pin_config_mux_asserts.sv */
// Port-level checks on the pin configuration and multiplexing block.
`timescale 1ns/10ps

module pinmux_checker (
   input wire logic                  ref_clk,         // System clock.
   input wire logic                  rstn,            // Reset, active low.
   input wire logic [7:0]            reg_addr,        // Register offset.
   input wire logic [15:0]           reg_wdata,       // Write data.
   input wire logic                  reg_wr,          // Write strobe.
   input wire logic                  reg_rd,          // Read strobe.
   input wire logic [15:0]           reg_rdata,       // Read data.
   input wire logic                  reg_rvalid,      // Read data valid.
   input wire pinmux_pkg::pin_pads_s pin_pads,        // Pad drive.
   input wire logic [12:0]           pin_edge_select, // Both-edge select.
   input wire logic [12:0]           pin_in_level,    // Active levels.
   input wire logic [12:0]           pin_event,       // Edge events.
   input wire pinmux_pkg::req_vec_t  func_req,        // Function levels.
   input wire logic                  hib_edge_pulse   // Edge hibernate.
);
   import pinmux_pkg::*;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);

   // ==========================================================================
   // Register port
   a_read_answer: assert property (reg_rd |=> reg_rvalid)
      else $error("read not answered next cycle");
   a_valid_cause: assert property (!reg_rd |=> !reg_rvalid)
      else $error("read valid without a read");
   a_rdata_holds: assert property ($changed(reg_rdata) |-> reg_rvalid)
      else $error("read data moved without a read");
   a_top_nibble_only: assert property (
      reg_rd && reg_addr == 8'h8f |=> reg_rdata[15:4] == 12'h0)
      else $error("last select register shows upper bits");
   a_input_released: assert property (
      reg_wr && reg_addr == 8'h86 && (&reg_wdata[12:0]) |->
      ##2 (pin_pads.oe_n == 13'h1fff && pin_pads.o == 13'h0))
      else $error("input pins still driven");

   // ==========================================================================
   // Pads and events
   a_pad_no_conflict: assert property (
      (pin_pads.o & pin_pads.oe_n) == 13'h0)
      else $error("pad drives high while released");
   a_event_rising: assert property (
      (pin_event & ~$past(pin_edge_select)
       & ~(pin_in_level & ~$past(pin_in_level))) == 13'h0)
      else $error("rising-only event without active rise");
   a_event_pulse: assert property (
      (pin_event & $past(pin_event)) == 13'h0)
      else $error("event longer than one cycle");
   a_hib_once: assert property (hib_edge_pulse |=> !hib_edge_pulse)
      else $error("edge hibernate pulse too long");
   a_hib_bit_idle: assert property (func_req[fn_hib_edge] == 1'b0)
      else $error("edge hibernate shown as a level");

   cover property (hib_edge_pulse);
   cover property (|pin_event);
   cover property (reg_rvalid && reg_rdata == 16'h0ffc);
endmodule

bind gpio_pin_config_mux pinmux_checker chk (
   .ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .reg_rvalid, .pin_pads, .pin_edge_select, .pin_in_level, .pin_event,
   .func_req, .hib_edge_pulse);

/* bench/gpio_pin_config_mux_tb.sv */
// Self-checking bench for the pin configuration and multiplexing block.
`timescale 1ns/10ps

module gpio_pin_config_mux_tb;
   import pinmux_pkg::*;

   typedef struct packed {
      logic [7:0]  addr;
      logic [15:0] wdata;
      logic [15:0] rdata;
   } reg_row_s;

   typedef struct packed {
      logic [3:0] pin;
      logic [3:0] code;
      in_func_e   idx;
      logic       edg;
      logic       hit;
   } in_row_s;

   localparam int LIM [4] = '{2, 4, 6, 8};
   localparam reg_row_s ROWS [8] = '{
      '{8'h86, 16'hffff, 16'h1fff}, '{8'h87, 16'hffff, 16'h1fff},
      '{8'h8c, 16'hfedc, 16'hfedc}, '{8'h8d, 16'h89ab, 16'h89ab},
      '{8'h8e, 16'h4567, 16'h4567}, '{8'h8f, 16'hffff, 16'h000f},
      '{8'h85, 16'hffff, 16'h00c0}, '{8'h91, 16'hffff, 16'h0000}};
   localparam reg_row_s DEFS [7] = '{
      '{8'h86, 16'h0, 16'h0ffc}, '{8'h87, 16'h0, 16'h0ffc},
      '{8'h8c, 16'h0, 16'h0013}, '{8'h8d, 16'h0, 16'h0000},
      '{8'h8e, 16'h0, 16'h0000}, '{8'h8f, 16'h0, 16'h0003},
      '{8'h85, 16'h0, 16'h0000}};
   localparam in_row_s INS [9] = '{
      '{4'h5, 4'h3, fn_hib_edge, 1'b1, 1'b1},
      '{4'h5, 4'h5, fn_hib_level, 1'b0, 1'b1},
      '{4'h6, 4'h3, fn_hib_edge, 1'b1, 1'b1},
      '{4'h6, 4'h4, fn_hib_level, 1'b0, 1'b1},
      '{4'h4, 4'h3, fn_hib_level, 1'b0, 1'b1},
      '{4'h4, 4'h4, fn_mask, 1'b0, 1'b1},
      '{4'h9, 4'h4, fn_hib_level, 1'b0, 1'b1},
      '{4'h8, 4'h4, fn_hib_edge, 1'b1, 1'b1},
      '{4'h5, 4'h8, fn_hib_level, 1'b0, 1'b0}};
   localparam out_src_e SRCS [3] = '{src_converter5_undervoltage_flag,
      src_converter5_clock_out, src_microphone_detect};

   logic        ref_clk;
   logic        rstn;
   logic [7:0]  reg_addr;
   logic [15:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [15:0] reg_rdata;
   logic        reg_rvalid;
   logic [12:0] pin_i;
   pin_pads_s   pin_pads;
   logic [12:0] pin_out_level;
   logic [12:0] pin_edge_select;
   src_vec_t    int_src;
   logic [12:0] pin_in_level;
   logic [12:0] pin_event;
   req_vec_t    func_req;
   logic        hib_edge_pulse;
   logic [12:0] ext;
   int          failures;
   int          n_tests;
   logic [15:0] base;
   logic [15:0] span;
   logic        seen;
   logic        g;

   gpio_pin_config_mux #(.DB_CYC0(LIM[0]), .DB_CYC1(LIM[1]),
      .DB_CYC2(LIM[2]), .DB_CYC3(LIM[3])) dut (
      .ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .reg_rvalid, .pin_i, .pin_pads, .pin_out_level, .pin_edge_select,
      .int_src, .pin_in_level, .pin_event, .func_req, .hib_edge_pulse);

   board_pins board (.pads(pin_pads), .ext(ext), .level(pin_i));

   // ==========================================================================
   // Tasks
   task automatic check(input logic [15:0] seen_v, input logic [15:0] exp);
      n_tests++;
      if (seen_v !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen_v,
            exp);
      end
   endtask

   task automatic final_report;
      if (failures == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      check(reg_rvalid, 1'b1);
      check(reg_rdata, exp);
   endtask

   task automatic settle;
      repeat (3) @(posedge ref_clk);
      #1;
   endtask

   task automatic pulse_count(input logic v, input logic [15:0] exp);
      logic [15:0] cnt;
      cnt = 16'h0;
      @(posedge ref_clk);
      ext[3] <= v;
      repeat (12) begin
         @(posedge ref_clk);
         #1;
         cnt = cnt + 16'(pin_event[3]);
      end
      check(cnt, exp);
   endtask

   task automatic measure(input logic [1:0] d, output logic [15:0] n);
      logic lvl;
      wr(8'h85, 16'(d) << 6);
      settle;
      lvl = pin_in_level[3];
      @(posedge ref_clk);
      ext[3] <= ~ext[3];
      for (n = 16'h0; n < 16'h28 && pin_in_level[3] === lvl; n++) begin
         @(posedge ref_clk);
         #1;
      end
      if (n == 16'h28) begin
         check(n, 16'h0);
         final_report;
      end
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // ==========================================================================
   // Main sequence
   initial begin
      rstn = 1'b0;
      reg_addr = 8'h0;
      reg_wdata = 16'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      pin_out_level = 13'h0;
      pin_edge_select = 13'h0;
      int_src = '0;
      ext = 13'h0;
      failures = 0;
      n_tests = 0;
      repeat (8) @(posedge ref_clk);
      rstn <= 1'b1;
      foreach (ROWS[i]) begin
         wr(ROWS[i].addr, ROWS[i].wdata);
         rd(ROWS[i].addr, ROWS[i].rdata);
      end
      // A second reset must bring back every factory default.
      @(posedge ref_clk);
      int_src <= (src_vec_t'(1) << src_por_n) | (src_vec_t'(1) << src_line_sw);
      rstn <= 1'b0;
      repeat (8) @(posedge ref_clk);
      rstn <= 1'b1;
      foreach (DEFS[i]) begin
         rd(DEFS[i].addr, DEFS[i].rdata);
      end
      check(pin_pads.oe_n, 16'h0ffc);
      check(pin_pads.o, 16'h1001);
      wr(8'h86, 16'h1fdf);
      wr(8'h87, 16'h0);
      foreach (SRCS[i]) begin
         wr(8'h8d, 16'(8 + i) << 4);
         @(posedge ref_clk);
         int_src <= src_vec_t'(1) << SRCS[i];
         settle;
         check({pin_pads.oe_n[5], pin_pads.o[5]}, 2'b01);
         @(posedge ref_clk);
         int_src <= ~(src_vec_t'(1) << SRCS[i]);
         settle;
         check({pin_pads.oe_n[5], pin_pads.o[5]}, 2'b00);
      end
      wr(8'h8d, 16'h00b0);
      @(posedge ref_clk);
      int_src <= '1;
      pin_out_level <= 13'h0020;
      settle;
      check({pin_pads.oe_n[5], pin_pads.o[5]}, 2'b01);
      @(posedge ref_clk);
      pin_out_level <= 13'h0;
      settle;
      check({pin_pads.oe_n[5], pin_pads.o[5]}, 2'b00);
      wr(8'h87, 16'h0020);
      settle;
      check({pin_pads.oe_n[5], pin_pads.o[5]}, 2'b00);
      @(posedge ref_clk);
      pin_out_level <= 13'h0020;
      settle;
      check({pin_pads.oe_n[5], pin_pads.o[5]}, 2'b10);
      wr(8'h86, 16'h1fff);
      wr(8'h87, 16'h1fff);
      wr(8'h8d, 16'h0);
      foreach (INS[i]) begin
         wr(8'h8c + 8'(INS[i].pin >> 2),
            16'(INS[i].code) << (4 * INS[i].pin[1:0]));
         seen = 1'b0;
         @(posedge ref_clk);
         ext[INS[i].pin] <= 1'b1;
         repeat (12) begin
            @(posedge ref_clk);
            #1;
            seen = seen | (INS[i].edg ? hib_edge_pulse : func_req[INS[i].idx]);
         end
         check(seen, INS[i].hit);
         @(posedge ref_clk);
         ext <= 13'h0;
         wr(8'h8c + 8'(INS[i].pin >> 2), 16'h0);
         settle;
      end
      wr(8'h87, 16'h1ff7);
      @(posedge ref_clk);
      ext[3] <= 1'b1;
      settle;
      settle;
      pulse_count(1'b0, 16'h1);
      check(pin_in_level[3], 1'b1);
      pulse_count(1'b1, 16'h0);
      @(posedge ref_clk);
      pin_edge_select <= 13'h0008;
      pulse_count(1'b0, 16'h1);
      pulse_count(1'b1, 16'h1);
      measure(2'h0, base);
      for (int d = 1; d < 4; d++) begin
         measure(2'(d), span);
         check(span - base, 16'(LIM[d] - LIM[0]));
      end
      g = ext[3];
      @(posedge ref_clk);
      ext[3] <= ~g;
      repeat (3) @(posedge ref_clk);
      pulse_count(g, 16'h0);
      final_report;
   end
endmodule
